// >>> hdl/tq_pkg.sv
// Purpose: Shared constants and types for the tagged queue task file
// Assumes: One clock, task file ports at their legacy port addresses
// Notes: Host-side software offsets are local to the host end
package tq_pkg;
    localparam int TAG_W = 6;
    localparam int QDEPTH = 64;
    localparam int TAG_LSB = 2;
    localparam int FEAT_DMA_BIT = 0;
    localparam logic [9:0] A_DATA = 10'h1F0;
    localparam logic [9:0] A_FEAT = 10'h1F1;
    localparam logic [9:0] A_SCNT = 10'h1F2;
    localparam logic [9:0] A_SNUM = 10'h1F3;
    localparam logic [9:0] A_CLO = 10'h1F4;
    localparam logic [9:0] A_CHI = 10'h1F5;
    localparam logic [9:0] A_UNIT = 10'h1F6;
    localparam logic [9:0] A_CMD = 10'h1F7;
    localparam logic [9:0] A_CTL = 10'h3F6;
    localparam logic [9:0] A_DADDR = 10'h3F7;
    localparam logic [7:0] OP_QREAD = 8'hA6;
    localparam logic [7:0] OP_QWRITE = 8'hA7;
    localparam logic [7:0] OP_SERVICE = 8'hA2;
    localparam logic [7:0] OP_IDENT = 8'hEC;
    localparam int ST_BSY = 7;
    localparam int ST_ACCEPT = 6;
    localparam int ST_DMA = 5;
    localparam int ST_SERVICE = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;
    localparam int RS_REL = 2;
    localparam int RS_IO = 1;
    localparam int RS_COD = 0;
    localparam int CTL_SRST = 2;
    localparam int CTL_NIEN = 1;
    localparam logic [7:0] ID_LAST_WORD = 8'hFF;
    localparam logic [7:0] ID_CAP_WORD = 8'h31;
    localparam int ID_CAP_BIT = 14;
    localparam logic [8:0] SECTOR_ZERO_BITS = 9'h000;
    localparam logic [7:0] H_OPCODE = 8'h00;
    localparam logic [7:0] H_TAGM = 8'h04;
    localparam logic [7:0] H_COUNT = 8'h08;
    localparam logic [7:0] H_LBA = 8'h0C;
    localparam logic [7:0] H_UNIT = 8'h10;
    localparam logic [7:0] H_EVENT = 8'h14;
    localparam logic [7:0] H_MASK = 8'h18;
    localparam logic [7:0] H_RESULT = 8'h1C;
    localparam logic [7:0] H_DEVST = 8'h20;
    localparam int EV_W = 3;
    localparam int EV_ISSUED = 0;
    localparam int EV_DEVIRQ = 1;
    localparam int EV_RESULT = 2;
    localparam logic [2:0] SETUP_LAST = 3'h6;
    localparam logic [2:0] RESULT_LAST = 3'h3;
    typedef struct packed {
        logic [7:0] opcode;
        logic dma;
        logic [7:0] count;
        logic [7:0] sector;
        logic [15:0] cyl;
        logic [7:0] unit;
    } entry_t;
    typedef enum logic [2:0] {H_IDLE, H_SEL, H_POLL, H_PWAIT, H_PCHK, H_SETUP, H_RES,
        H_RWAIT} hstate_t;
endpackage

// >>> hdl/taskfile_if.sv
// Purpose: Task file register bus between host adapter and device
// Assumes: Both ends on one clock; read data valid the cycle after rd
// Notes: Separate write and read data, no tristate
`timescale 1ns/10ps
`default_nettype none
interface taskfile_if;
    logic [9:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic intrq;
    modport device (input addr, input wdata, input wr, input rd, output rdata, output intrq);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input intrq);
endinterface
`default_nettype wire

// >>> hdl/tag_queue.sv
// Purpose: Queue of pending commands indexed by tag
// Assumes: Two clear ports may hit different tags in one cycle
// Notes: Entry read is combinational on rd_tag
`timescale 1ns/10ps
`default_nettype none
module tag_queue #(
    parameter int DEPTH = tq_pkg::QDEPTH,
    parameter int TW = tq_pkg::TAG_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic [TW-1:0] wr_tag,
    input wire tq_pkg::entry_t wr_entry,
    input wire logic clr_a,
    input wire logic [TW-1:0] clr_a_tag,
    input wire logic clr_b,
    input wire logic [TW-1:0] clr_b_tag,
    input wire logic flush,
    input wire logic [TW-1:0] rd_tag,
    output logic [DEPTH-1:0] valid,
    output tq_pkg::entry_t rd_entry
);
    typedef struct packed {
        logic [DEPTH-1:0] valid;
    } qstate_t;
    qstate_t r;
    qstate_t n;
    tq_pkg::entry_t mem [DEPTH];

    always_comb begin
        n = r;
        for (int i = 0; i < DEPTH; i++) begin
            if (flush || (clr_a && clr_a_tag == TW'(i)) || (clr_b && clr_b_tag == TW'(i))) begin
                n.valid[i] = 1'b0;
            end
            if (wr && wr_tag == TW'(i)) begin
                n.valid[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Entry payload, held until the same tag is written again; service and flush leave it in place
    always_ff @(posedge clk) begin
        if (wr) begin
            mem[wr_tag] <= wr_entry;
        end
    end

    assign valid = r.valid;
    assign rd_entry = mem[rd_tag];
endmodule
`default_nettype wire

// >>> hdl/tq_device.sv
// Purpose: Device end of the task file with tagged command queuing
// Assumes: Host keeps its issue order; media side driven by user ports
// Notes: Data phase of queued commands is handed to the user side
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tq_device #(
    parameter int TW = tq_pkg::TAG_W
) (
    input wire logic clk,
    input wire logic rst,
    taskfile_if.device bus,
    input wire logic svc_req,
    input wire logic [TW-1:0] svc_tag,
    input wire logic abort_req,
    input wire logic [TW-1:0] abort_tag,
    output logic go_valid,
    output logic go_queued,
    output logic [TW-1:0] go_tag,
    output tq_pkg::entry_t go_entry,
    output logic flushed
);
    typedef struct packed {
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] clo;
        logic [7:0] chi;
        logic [7:0] unit;
        logic srst;
        logic nien;
        logic err;
        logic abrt;
        logic svc;
        logic [TW-1:0] svc_tag;
        logic sel_view;
        logic [TW-1:0] stag;
        logic [2:0] reason;
        logic [15:0] bcount;
        logic dma_st;
        logic drq;
        logic [7:0] id_cnt;
        logic intrq;
        logic [15:0] rdata;
        logic go_valid;
        logic go_queued;
        logic [TW-1:0] go_tag;
        tq_pkg::entry_t go_entry;
        logic flushed;
    } dstate_t;
    dstate_t r;
    dstate_t n;

    logic q_wr;
    logic q_clr_a;
    logic q_clr_b;
    logic q_flush;
    logic [TW-1:0] cmd_tag;
    logic [tq_pkg::QDEPTH-1:0] q_valid;
    tq_pkg::entry_t q_new;
    tq_pkg::entry_t q_out;
    logic [7:0] status;
    logic [7:0] op;

    tag_queue #(.DEPTH(tq_pkg::QDEPTH), .TW(TW)) queue (
        .clk(clk),
        .rst(rst),
        .wr(q_wr),
        .wr_tag(cmd_tag),
        .wr_entry(q_new),
        .clr_a(q_clr_a),
        .clr_a_tag(cmd_tag),
        .clr_b(q_clr_b),
        .clr_b_tag(abort_tag),
        .flush(q_flush),
        .rd_tag(r.svc_tag),
        .valid(q_valid),
        .rd_entry(q_out)
    );

    always_comb begin
        n = r;
        n.go_valid = 1'b0;
        n.flushed = 1'b0;
        q_wr = 1'b0;
        q_clr_a = 1'b0;
        q_clr_b = 1'b0;
        q_flush = 1'b0;
        op = bus.wdata[7:0];
        cmd_tag = r.feat[7:tq_pkg::TAG_LSB];
        q_new = '{opcode: op, dma: r.feat[tq_pkg::FEAT_DMA_BIT], count: r.scnt,
            sector: r.snum, cyl: {r.chi, r.clo}, unit: r.unit};
        status = '0;
        status[tq_pkg::ST_BSY] = 1'b0;
        status[tq_pkg::ST_ACCEPT] = ~r.drq;
        status[tq_pkg::ST_DMA] = r.dma_st;
        status[tq_pkg::ST_SERVICE] = r.svc;
        status[tq_pkg::ST_DRQ] = r.drq;
        status[tq_pkg::ST_ERR] = r.err;

        // Service request from the media side
        if (svc_req && !r.svc && q_valid[svc_tag]) begin
            n.svc = 1'b1;
            n.svc_tag = svc_tag;
            n.intrq = ~r.nien;
        end
        // Device-initiated abort of one queued entry
        if (abort_req && q_valid[abort_tag]) begin
            q_clr_b = 1'b1;
            n.err = 1'b1;
            n.abrt = 1'b1;
            n.stag = abort_tag;
            n.sel_view = 1'b1;
            n.intrq = ~r.nien;
            if (r.svc && r.svc_tag == abort_tag) begin
                n.svc = 1'b0;
            end
        end

        if (bus.wr) begin
            unique case (bus.addr)
                tq_pkg::A_FEAT: n.feat = bus.wdata[7:0];
                tq_pkg::A_SCNT: begin
                    n.scnt = bus.wdata[7:0];
                    n.sel_view = 1'b0;
                end
                tq_pkg::A_SNUM: n.snum = bus.wdata[7:0];
                tq_pkg::A_CLO: n.clo = bus.wdata[7:0];
                tq_pkg::A_CHI: n.chi = bus.wdata[7:0];
                tq_pkg::A_UNIT: n.unit = bus.wdata[7:0];
                tq_pkg::A_CTL: begin
                    n.nien = bus.wdata[tq_pkg::CTL_NIEN];
                    n.srst = bus.wdata[tq_pkg::CTL_SRST];
                    if (bus.wdata[tq_pkg::CTL_SRST] && !r.srst) begin
                        q_flush = 1'b1;
                        n.flushed = 1'b1;
                        n.svc = 1'b0;
                        n.drq = 1'b0;
                    end
                end
                tq_pkg::A_CMD: begin
                    n.err = 1'b0;
                    n.abrt = 1'b0;
                    n.sel_view = 1'b0;
                    n.reason = '0;
                    if (op == tq_pkg::OP_QREAD || op == tq_pkg::OP_QWRITE) begin
                        if (cmd_tag == '0) begin
                            // Overlapped only: released and handed over, never queued
                            n.go_valid = 1'b1;
                            n.go_queued = 1'b0;
                            n.go_tag = '0;
                            n.go_entry = q_new;
                            n.reason[tq_pkg::RS_REL] = 1'b1;
                            n.dma_st = q_new.dma;
                        end else if (q_valid[cmd_tag]) begin
                            q_clr_a = 1'b1;
                            n.err = 1'b1;
                            n.abrt = 1'b1;
                            n.stag = cmd_tag;
                            n.sel_view = 1'b1;
                            n.intrq = ~r.nien;
                            if (r.svc && r.svc_tag == cmd_tag) begin
                                n.svc = 1'b0;
                            end
                        end else begin
                            q_wr = 1'b1;
                        end
                    end else if (op == tq_pkg::OP_SERVICE) begin
                        if (r.svc) begin
                            n.svc = 1'b0;
                            n.sel_view = 1'b1;
                            n.stag = r.svc_tag;
                            n.reason[tq_pkg::RS_IO] = (q_out.opcode == tq_pkg::OP_QREAD);
                            n.reason[tq_pkg::RS_COD] = 1'b0;
                            n.bcount = 16'({q_out.count, tq_pkg::SECTOR_ZERO_BITS});
                            n.dma_st = q_out.dma;
                            n.go_valid = 1'b1;
                            n.go_queued = 1'b1;
                            n.go_tag = r.svc_tag;
                            n.go_entry = q_out;
                            cmd_tag = r.svc_tag;
                            q_clr_a = 1'b1;
                        end else begin
                            n.err = 1'b1;
                            n.abrt = 1'b1;
                        end
                    end else begin
                        // Non-tagged: drop all queued work silently, then run it
                        q_flush = 1'b1;
                        n.flushed = 1'b1;
                        n.svc = 1'b0;
                        n.dma_st = 1'b0;
                        n.drq = (op == tq_pkg::OP_IDENT);
                        n.id_cnt = '0;
                        n.go_valid = (op != tq_pkg::OP_IDENT);
                        n.go_queued = 1'b0;
                        n.go_tag = '0;
                        n.go_entry = q_new;
                    end
                end
                default: ;
            endcase
        end

        if (bus.rd) begin
            n.rdata = '0;
            unique case (bus.addr)
                tq_pkg::A_DATA: begin
                    if (r.drq) begin
                        if (r.id_cnt == tq_pkg::ID_CAP_WORD) begin
                            n.rdata[tq_pkg::ID_CAP_BIT] = 1'b1;
                        end
                        n.id_cnt = r.id_cnt + 8'h01;
                        n.drq = (r.id_cnt != tq_pkg::ID_LAST_WORD);
                    end
                end
                tq_pkg::A_FEAT: n.rdata[tq_pkg::ER_ABRT] = r.abrt;
                tq_pkg::A_SCNT: n.rdata[7:0] = r.sel_view ? {5'h00, r.reason} : r.scnt;
                tq_pkg::A_SNUM: n.rdata[7:0] = r.sel_view ? 8'({r.stag}) : r.snum;
                tq_pkg::A_CLO: n.rdata[7:0] = r.sel_view ? r.bcount[7:0] : r.clo;
                tq_pkg::A_CHI: n.rdata[7:0] = r.sel_view ? r.bcount[15:8] : r.chi;
                tq_pkg::A_UNIT: n.rdata[7:0] = r.unit;
                tq_pkg::A_CMD: begin
                    n.rdata[7:0] = status;
                    n.intrq = 1'b0;
                end
                tq_pkg::A_CTL: n.rdata[7:0] = status;
                tq_pkg::A_DADDR: n.rdata[7:0] = {4'h0, r.unit[3:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.rdata = r.rdata;
    assign bus.intrq = r.intrq;
    assign go_valid = r.go_valid;
    assign go_queued = r.go_queued;
    assign go_tag = r.go_tag;
    assign go_entry = r.go_entry;
    assign flushed = r.flushed;
endmodule
`default_nettype wire

// >>> hdl/tq_host.sv
// Purpose: Host adapter end issuing queued commands over the task file
// Assumes: Software port reads answer one cycle after sw_rd
// Notes: Events are sticky, write one to clear; irq is a level
`timescale 1ns/10ps
`default_nettype none
module tq_host (
    input wire logic clk,
    input wire logic rst,
    taskfile_if.host bus,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic irq
);
    typedef struct packed {
        tq_pkg::hstate_t state;
        logic [2:0] step;
        logic [7:0] opcode;
        logic [7:0] tagm;
        logic [7:0] count;
        logic [23:0] lba;
        logic [7:0] unit;
        logic [tq_pkg::EV_W-1:0] ev;
        logic [tq_pkg::EV_W-1:0] mask;
        logic [3:0][7:0] result;
        logic [7:0] devst;
        logic intrq_d;
        logic [9:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic [31:0] sw_rdata;
        logic irq;
    } hst_t;
    hst_t r;
    hst_t n;
    logic [tq_pkg::EV_W-1:0] ev_set;

    always_comb begin
        n = r;
        n.wr = 1'b0;
        n.rd = 1'b0;
        n.intrq_d = bus.intrq;
        ev_set = '0;
        ev_set[tq_pkg::EV_DEVIRQ] = bus.intrq && !r.intrq_d;
        unique case (r.state)
            tq_pkg::H_IDLE: ;
            tq_pkg::H_SEL: begin
                n.wr = 1'b1;
                n.addr = tq_pkg::A_UNIT;
                n.wdata = {8'h00, r.unit};
                n.state = tq_pkg::H_POLL;
            end
            tq_pkg::H_POLL: begin
                n.rd = 1'b1;
                n.addr = tq_pkg::A_CMD;
                n.state = tq_pkg::H_PWAIT;
            end
            tq_pkg::H_PWAIT: n.state = tq_pkg::H_PCHK;
            tq_pkg::H_PCHK: begin
                n.devst = bus.rdata[7:0];
                if (bus.rdata[tq_pkg::ST_ACCEPT] && !bus.rdata[tq_pkg::ST_BSY]) begin
                    n.step = 3'h1;
                    n.state = tq_pkg::H_SETUP;
                end else begin
                    n.state = tq_pkg::H_POLL;
                end
            end
            tq_pkg::H_SETUP: begin
                n.wr = 1'b1;
                n.step = r.step + 3'h1;
                unique case (r.step)
                    3'h1: {n.addr, n.wdata} = {tq_pkg::A_FEAT, 8'h00, r.tagm};
                    3'h2: {n.addr, n.wdata} = {tq_pkg::A_SCNT, 8'h00, r.count};
                    3'h3: {n.addr, n.wdata} = {tq_pkg::A_SNUM, 8'h00, r.lba[7:0]};
                    3'h4: {n.addr, n.wdata} = {tq_pkg::A_CLO, 8'h00, r.lba[15:8]};
                    3'h5: {n.addr, n.wdata} = {tq_pkg::A_CHI, 8'h00, r.lba[23:16]};
                    default: {n.addr, n.wdata} = {tq_pkg::A_CMD, 8'h00, r.opcode};
                endcase
                if (r.step == tq_pkg::SETUP_LAST) begin
                    ev_set[tq_pkg::EV_ISSUED] = 1'b1;
                    n.step = '0;
                    n.state = (r.opcode == tq_pkg::OP_SERVICE) ? tq_pkg::H_RES : tq_pkg::H_IDLE;
                end
            end
            tq_pkg::H_RES: begin
                n.rd = 1'b1;
                n.addr = tq_pkg::A_SCNT + 10'(r.step);
                n.state = tq_pkg::H_RWAIT;
            end
            tq_pkg::H_RWAIT: begin
                n.result[r.step[1:0]] = bus.rdata[7:0];
                n.step = r.step + 3'h1;
                n.state = tq_pkg::H_RES;
                if (r.step == tq_pkg::RESULT_LAST) begin
                    ev_set[tq_pkg::EV_RESULT] = 1'b1;
                    n.state = tq_pkg::H_IDLE;
                end
            end
            default: n.state = tq_pkg::H_IDLE;
        endcase
        if (r.state == tq_pkg::H_RWAIT) begin
            n.state = tq_pkg::H_RWAIT;
            n.step = r.step;
            n.result = r.result;
            if (!r.rd) begin
                n.result[r.step[1:0]] = bus.rdata[7:0];
                n.step = r.step + 3'h1;
                n.state = (r.step == tq_pkg::RESULT_LAST) ? tq_pkg::H_IDLE : tq_pkg::H_RES;
                ev_set[tq_pkg::EV_RESULT] = (r.step == tq_pkg::RESULT_LAST);
            end
        end

        if (sw_wr) begin
            unique case (sw_addr)
                tq_pkg::H_OPCODE: begin
                    if (r.state == tq_pkg::H_IDLE) begin
                        n.opcode = sw_wdata[7:0];
                        n.state = tq_pkg::H_SEL;
                    end
                end
                tq_pkg::H_TAGM: n.tagm = sw_wdata[7:0];
                tq_pkg::H_COUNT: n.count = sw_wdata[7:0];
                tq_pkg::H_LBA: n.lba = sw_wdata[23:0];
                tq_pkg::H_UNIT: n.unit = sw_wdata[7:0];
                tq_pkg::H_EVENT: n.ev = r.ev & ~sw_wdata[tq_pkg::EV_W-1:0];
                tq_pkg::H_MASK: n.mask = sw_wdata[tq_pkg::EV_W-1:0];
                default: ;
            endcase
        end
        n.ev = n.ev | ev_set;
        n.irq = |(n.ev & n.mask);

        if (sw_rd) begin
            n.sw_rdata = '0;
            unique case (sw_addr)
                tq_pkg::H_OPCODE: n.sw_rdata[7:0] = r.opcode;
                tq_pkg::H_TAGM: n.sw_rdata[7:0] = r.tagm;
                tq_pkg::H_COUNT: n.sw_rdata[7:0] = r.count;
                tq_pkg::H_LBA: n.sw_rdata[23:0] = r.lba;
                tq_pkg::H_UNIT: n.sw_rdata[7:0] = r.unit;
                tq_pkg::H_EVENT: n.sw_rdata[tq_pkg::EV_W-1:0] = r.ev;
                tq_pkg::H_MASK: n.sw_rdata[tq_pkg::EV_W-1:0] = r.mask;
                tq_pkg::H_RESULT: n.sw_rdata = r.result;
                tq_pkg::H_DEVST: n.sw_rdata[8:0] = {r.state != tq_pkg::H_IDLE, r.devst};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign bus.addr = r.addr;
    assign bus.wdata = r.wdata;
    assign bus.wr = r.wr;
    assign bus.rd = r.rd;
    assign sw_rdata = r.sw_rdata;
    assign irq = r.irq;
endmodule
`default_nettype wire

// >>> testbench/tq_chk.sv
// Purpose: Bus checks on the task file joining both ends
// Assumes: Both ends on clk
// Notes: Reason view follows a service-select write
`timescale 1ns/10ps
`default_nettype none
module tq_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic intrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence svc_rd(a);
        wr && addr == tq_pkg::A_CMD && wdata[7:0] == tq_pkg::OP_SERVICE ##[1:12] rd && addr == a;
    endsequence
    AST_EXCL: assert property (!(wr && rd)) else $error("write and read together");
    AST_CMD_LAST: assert property (wr && addr == tq_pkg::A_CMD |-> $past(wr) &&
        $past(addr) == tq_pkg::A_CHI) else $error("opcode not after setup");
    AST_ACCEPT: assert property (rd && addr == tq_pkg::A_CMD |=>
        rdata[6] == !rdata[3] && !rdata[7]) else $error("accept flag wrong");
    AST_INTRQ_CLR: assert property (rd && addr == tq_pkg::A_CMD |=> !intrq)
        else $error("intrq kept after status read");
    AST_INTRQ_HOLD: assert property (intrq && !rd && !wr |=> intrq)
        else $error("intrq dropped");
    AST_REASON: assert property (svc_rd(tq_pkg::A_SCNT) |=>
        rdata[7:3] == 5'h00 && !rdata[0]) else $error("reason byte wrong");
    AST_TAG: assert property (svc_rd(tq_pkg::A_SNUM) |=> rdata[7:6] == 2'h0)
        else $error("tag byte wrong");
    AST_BCLO: assert property (svc_rd(tq_pkg::A_CLO) |=> rdata[7:0] == 8'h00)
        else $error("byte count low wrong");
    AST_HOLD: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
    cover property (svc_rd(tq_pkg::A_CLO));
    cover property ($rose(intrq));
    cover property (wr && addr == tq_pkg::A_CMD && wdata[7:0] == tq_pkg::OP_QWRITE);
endmodule
`default_nettype wire

// >>> testbench/test_ata_tagged_queue_taskfile.sv
// Purpose: Host and device ends joined, driven from software and media sides
// Assumes: Mask enables only the device interrupt event
// Notes: Expected values built from tag, count and opcode
`timescale 1ns/10ps
`default_nettype none
module test_ata_tagged_queue_taskfile;
    logic clk = 0, rst = 1, sw_wr = 0, sw_rd = 0, svc_req = 0, abort_req = 0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, d;
    logic [5:0] svc_tag = 6'h00, abort_tag = 6'h00, go_tag, g_tag;
    logic irq, go_valid, go_queued, flushed, g_q;
    tq_pkg::entry_t go_entry, g_e;
    int num_errors = 0, cmp_count = 0, go_n = 0, fl_n = 0;
    taskfile_if tf();
    tq_host tq_host_inst (.clk, .rst, .bus(tf.host), .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
        .sw_rdata, .irq);
    tq_device tq_device_inst (.clk, .rst, .bus(tf.device), .svc_req, .svc_tag, .abort_req,
        .abort_tag, .go_valid, .go_queued, .go_tag, .go_entry, .flushed);
    tq_chk tq_chk_inst (.clk, .rst, .addr(tf.addr), .wdata(tf.wdata), .wr(tf.wr), .rd(tf.rd),
        .rdata(tf.rdata), .intrq(tf.intrq));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (go_valid) begin
            g_tag <= go_tag;
            g_q <= go_queued;
            g_e <= go_entry;
            go_n <= go_n + 1;
        end
        if (flushed) fl_n <= fl_n + 1;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("Errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic sw_w(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_r(input logic [7:0] a);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic wait_ev(input int b);
        d = 32'h0;
        for (int i = 0; i < 300 && d[b] !== 1'b1; i++) sw_r(tq_pkg::H_EVENT);
        if (d[b] !== 1'b1) begin
            num_errors++;
            results();
        end
        if (b == tq_pkg::EV_DEVIRQ) chk("irq", {31'h0, irq}, 32'h1);
        sw_w(tq_pkg::H_EVENT, 32'h1 << b);
        d = 32'h0;
    endtask
    task automatic issue(input logic [7:0] op, input logic [7:0] tm, input logic [7:0] cnt);
        sw_w(tq_pkg::H_EVENT, 32'h7);
        sw_w(tq_pkg::H_TAGM, {24'h0, tm});
        sw_w(tq_pkg::H_COUNT, {24'h0, cnt});
        sw_w(tq_pkg::H_OPCODE, {24'h0, op});
        wait_ev(tq_pkg::EV_ISSUED);
    endtask
    task automatic svc(input logic [5:0] t, input logic ab);
        @(posedge clk);
        svc_tag <= t;
        abort_tag <= t;
        svc_req <= !ab;
        abort_req <= ab;
        @(posedge clk);
        svc_req <= 1'b0;
        abort_req <= 1'b0;
    endtask
    task automatic t_queued(input logic [7:0] op, input logic [5:0] t, input logic dm,
        input logic [7:0] cnt, input logic [7:0] rs);
        int n;
        issue(op, {t, 1'b0, dm}, cnt);
        n = go_n;
        svc(t, 1'b0);
        wait_ev(tq_pkg::EV_DEVIRQ);
        issue(tq_pkg::OP_SERVICE, 8'h00, 8'h00);
        wait_ev(tq_pkg::EV_RESULT);
        sw_r(tq_pkg::H_RESULT);
        chk("result", d, {cnt[6:0], 1'b0, 8'h00, 2'h0, t, rs});
        chk("go count", go_n - n, 1);
        chk("go", {g_q, g_tag, g_e.opcode, g_e.dma, g_e.count}, {1'b1, t, op, dm, cnt});
    endtask
    initial begin
        int n;
        int f;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        sw_r(tq_pkg::H_EVENT);
        chk("event", d, 32'h0);
        sw_w(tq_pkg::H_MASK, 32'h2);
        t_queued(tq_pkg::OP_QREAD, 6'h05, 1'b1, 8'h03, 8'h02);
        t_queued(tq_pkg::OP_QWRITE, 6'h3F, 1'b0, 8'h81, 8'h00);
        n = go_n;
        issue(tq_pkg::OP_QREAD, 8'h01, 8'h01);
        chk("tag0 go", go_n - n, 1);
        chk("tag0 queued", {31'h0, g_q}, 32'h0);
        issue(tq_pkg::OP_QREAD, 8'h1C, 8'h01);
        issue(tq_pkg::OP_QREAD, 8'h1C, 8'h01);
        wait_ev(tq_pkg::EV_DEVIRQ);
        issue(tq_pkg::OP_QWRITE, 8'h25, 8'h02);
        sw_r(tq_pkg::H_DEVST);
        chk("abort err", {31'h0, d[tq_pkg::ST_ERR]}, 32'h1);
        svc(6'h09, 1'b1);
        wait_ev(tq_pkg::EV_DEVIRQ);
        issue(tq_pkg::OP_QREAD, 8'h10, 8'h01);
        n = go_n;
        f = fl_n;
        issue(8'h20, 8'h00, 8'h01);
        chk("flush", fl_n - f, 1);
        chk("direct go", {g_q, 31'(go_n - n)}, {1'b0, 31'h1});
        sw_w(tq_pkg::H_EVENT, 32'h7);
        svc(6'h04, 1'b0);
        sw_r(tq_pkg::H_EVENT);
        chk("no service", {31'h0, d[1]}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
